// ---- cpu_side.sv ----
/* fetch, data and debugger side: one request per call. assumes bench clock. */
`timescale 1ns/1ns
module cpu_side (
  input  wire        clock_i,
  output reg  [4:0]  req_o = 5'h00,
  output reg  [11:0] addr_o = 12'h000,
  output reg  [31:0] wd_o = 32'h00000000
);
  task go(input [4:0] r, input [11:0] a, input [31:0] d);
    begin
      req_o = r;
      addr_o = a;
      wd_o = d;
      @(negedge clock_i);
      req_o = 5'h00;
      addr_o = ~a;
    end
  endtask
endmodule

// ---- flash_ctl.v ----
/*
  flash array controller: single-cycle reads, 1 KB block erase,
  word program, per-pair read-only and execute-only protection.
  assumes one request per cycle, requests synchronous to clock_i.
  assumes prot_i is held steady while a request is presented.
  a modify request while busy_o is high is dropped with no pulse.
*/
// Function
// R1 - 16 KB array in sixteen 1 KB blocks, each erased alone
// R2 - erase leaves every bit of that block at one
// R3 - protection applied per 2 KB pair of adjacent blocks
// R4 - each pair is open, read-only or execute-only
// R5 - read-only pair refuses erase and program, still readable
// R6 - execute-only pair refuses erase and program always
// R7 - execute-only pair answers only instruction fetches
// R8 - reads finish in one clock, no wait states
// R9 - refused access sets sticky violation flag, software clears
`timescale 1ns/1ns
`include "flash_ctl_regs.vh"
module flash_ctl #(
  parameter WORDS = `FL_WORDS
) (
  // clock and reset
  input  wire                   clock_i,
  input  wire                   rst_i,
  // instruction fetch
  input  wire                   fetch_i,
  input  wire [`FL_ADDR_W-1:0]  fetch_addr_i,
  output reg  [`FL_WORD_W-1:0]  fetch_data_o,
  // data and debugger read
  input  wire                   data_rd_i,
  input  wire                   dbg_rd_i,
  input  wire [`FL_ADDR_W-1:0]  data_addr_i,
  output reg  [`FL_WORD_W-1:0]  data_data_o,
  output reg                    data_deny_o,
  // program and erase
  input  wire                   prog_i,
  input  wire                   erase_i,
  input  wire [`FL_ADDR_W-1:0]  mod_addr_i,
  input  wire [`FL_WORD_W-1:0]  prog_data_i,
  output reg                    mod_deny_o,
  output wire                   busy_o,
  output reg                    done_o,
  // protection settings, two bits per pair
  input  wire [2*`FL_PAIRS-1:0] prot_i,
  // violation flag
  input  wire                   viol_clr_i,
  output reg                    viol_o
);

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  localparam ST_IDLE  = 2'b01;
  localparam ST_ERASE = 2'b10;

  reg [`FL_WORD_W-1:0]      mem [0:WORDS-1]; // R1
  reg [1:0]                 state_q;
  reg [1:0]                 state_d;
  reg [`FL_BLK_W-1:0]       blk_q;
  reg [`FL_BLK_W-1:0]       blk_d;
  reg [`FL_WORD_IN_BLK-1:0] idx_q;
  reg [`FL_WORD_IN_BLK-1:0] idx_d;
  reg                       done_d;
  reg                       mod_deny_d;
  reg                       data_deny_d;
  reg                       viol_d;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  wire [`FL_PAIR_W-1:0]      mpair     = mod_addr_i[`FL_ADDR_W-1:`FL_PAIR_LSB]; // R3
  wire [`FL_PAIR_W-1:0]      dpair     = data_addr_i[`FL_ADDR_W-1:`FL_PAIR_LSB];
  wire [`FL_BLK_W-1:0]       mblk      = mod_addr_i[`FL_ADDR_W-1:`FL_BLK_LSB];
  wire [`FL_WORD_IN_BLK-1:0] idx_one   = {{(`FL_WORD_IN_BLK-1){1'b0}}, 1'b1};
  wire                       idle      = (state_q == ST_IDLE);
  wire                       erasing   = (state_q == ST_ERASE);
  wire                       modify    = (prog_i || erase_i) && idle;
  wire                       dread     = data_rd_i || dbg_rd_i;
  wire                       deny_m;
  wire                       deny_r;
  wire                       mod_ok    = modify && !deny_m;
  wire                       mod_bad   = modify && deny_m;
  wire                       read_bad  = dread && deny_r;
  wire                       do_erase  = mod_ok && erase_i;
  wire                       do_prog   = mod_ok && prog_i && !erase_i;
  wire                       last_word = (idx_q == {`FL_WORD_IN_BLK{1'b1}});

  // ----------------------------------------
  // protection check
  // ----------------------------------------
  flash_pair_prot u_prot_mod (
    .mode_i        (prot_i[2*mpair +: 2]), // R4
    .modify_i      (modify),
    .data_rd_i     (1'b0),
    .deny_modify_o (deny_m), // R6
    .deny_read_o   ()
  );
  flash_pair_prot u_prot_rd (
    .mode_i        (prot_i[2*dpair +: 2]),
    .modify_i      (1'b0),
    .data_rd_i     (dread),
    .deny_modify_o (),
    .deny_read_o   (deny_r) // R7
  );

  assign busy_o = erasing;

  // ----------------------------------------
  // array write port
  // ----------------------------------------
  wire                  wr_en   = do_prog || erasing;
  wire [`FL_ADDR_W-1:0] wr_addr = erasing ? {blk_q, idx_q} : mod_addr_i;
  wire [`FL_WORD_W-1:0] wr_word = mem[mod_addr_i] & prog_data_i;
  wire [`FL_WORD_W-1:0] wr_data = erasing ? `FL_ERASED : wr_word; // R2

  always @(posedge clock_i) begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // ----------------------------------------
  // instruction fetch port
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (fetch_i)
      fetch_data_o <= mem[fetch_addr_i]; // R8
  end

  // ----------------------------------------
  // data and debugger read port
  // ----------------------------------------
  wire [`FL_WORD_W-1:0] rd_word  = mem[data_addr_i];
  wire [`FL_WORD_W-1:0] rd_value = deny_r ? {`FL_WORD_W{1'b0}} : rd_word;

  always @(posedge clock_i) begin
    if (dread)
      data_data_o <= rd_value; // R8
  end

  // ----------------------------------------
  // erase sequencer
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    blk_d   = blk_q;
    idx_d   = idx_q;
    done_d  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (do_erase) begin
          state_d = ST_ERASE; // R1
          blk_d   = mblk;
          idx_d   = {`FL_WORD_IN_BLK{1'b0}};
        end else if (do_prog) begin
          done_d  = 1'b1;
        end
      end
      ST_ERASE: begin
        idx_d = idx_q + idx_one;
        if (last_word) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      blk_q   <= {`FL_BLK_W{1'b0}};
      idx_q   <= {`FL_WORD_IN_BLK{1'b0}};
      done_o  <= 1'b0;
    end else begin
      state_q <= state_d;
      blk_q   <= blk_d;
      idx_q   <= idx_d;
      done_o  <= done_d;
    end
  end

  // ----------------------------------------
  // refusal pulses
  // ----------------------------------------
  always @* begin
    mod_deny_d  = mod_bad; // R5
    data_deny_d = read_bad; // R7
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mod_deny_o  <= 1'b0;
      data_deny_o <= 1'b0;
    end else begin
      mod_deny_o  <= mod_deny_d;
      data_deny_o <= data_deny_d;
    end
  end

  // ----------------------------------------
  // sticky violation flag
  // ----------------------------------------
  always @* begin
    if (mod_bad || read_bad)
      viol_d = 1'b1; // R9
    else if (viol_clr_i)
      viol_d = 1'b0;
    else
      viol_d = viol_o;
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      viol_o <= 1'b0;
    else
      viol_o <= viol_d;
  end

endmodule

// ---- flash_ctl_regs.vh ----
/*
  constants for the flash block erase and protection controller.
  assumes inclusion by bare name from the design files.
*/
`ifndef FLASH_CTL_REGS_VH
`define FLASH_CTL_REGS_VH

// ----------------------------------------
// geometry
// ----------------------------------------
`define FL_WORD_W      32
`define FL_ADDR_W      12
`define FL_WORDS       4096
`define FL_BLK_W       4
`define FL_BLK_LSB     8
`define FL_PAIR_W      3
`define FL_PAIR_LSB    9
`define FL_WORD_IN_BLK 8
`define FL_BLK_WORDS   256
`define FL_PAIRS       8
`define FL_ERASED      32'hFFFFFFFF

// ----------------------------------------
// protection modes
// ----------------------------------------
`define PROT_OPEN      2'h0
`define PROT_RDONLY    2'h1
`define PROT_XONLY     2'h2

`endif

// ---- flash_ctl_sva.sv ----
/* checker for flash_ctl. assumes it is bound to the flash_ctl ports. */
`timescale 1ns/1ns
module flash_ctl_sva (
  input wire        clock_i, rst_i, data_rd_i, dbg_rd_i, data_deny_o, prog_i, erase_i,
  input wire        mod_deny_o, busy_o, done_o, viol_clr_i, viol_o,
  input wire [11:0] data_addr_i, mod_addr_i,
  input wire [31:0] data_data_o,
  input wire [15:0] prot_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire [1:0] rm = prot_i[2*data_addr_i[11:9] +: 2];
  wire [1:0] mm = prot_i[2*mod_addr_i[11:9] +: 2];
  wire       rq = data_rd_i | dbg_rd_i;
  wire       mq = (prog_i | erase_i) & !busy_o;
  a_xonly_read: assert property (rq && rm == 2'h2 |=> data_deny_o && data_data_o == 0)
    else $error("read not refused");
  a_open_read: assert property (rq && rm != 2'h2 |=> !data_deny_o)
    else $error("read refused");
  a_prot_modify: assert property (mq && (mm[0] ^ mm[1]) |=> mod_deny_o && !busy_o)
    else $error("modify not refused");
  a_open_modify: assert property (mq && mm[0] == mm[1] |=> !mod_deny_o)
    else $error("modify refused");
  a_erase_start: assert property (erase_i && mq && mm == 2'h0 |=> busy_o [*8])
    else $error("erase not started");
  a_erase_time: assert property ($rose(busy_o) |-> ##256 done_o && !busy_o)
    else $error("erase length wrong");
  a_deny_flag: assert property (data_deny_o || mod_deny_o |-> viol_o)
    else $error("flag not set");
  a_flag_sticky: assert property (viol_o && !viol_clr_i |=> viol_o)
    else $error("flag lost");
endmodule
bind flash_ctl flash_ctl_sva u_sva (.clock_i, .rst_i, .data_rd_i, .dbg_rd_i, .data_deny_o,
  .prog_i, .erase_i, .mod_deny_o, .busy_o, .done_o, .viol_clr_i, .viol_o, .data_addr_i,
  .mod_addr_i, .data_data_o, .prot_i);

// ---- flash_pair_prot.v ----
/*
  protection check for one 2 KB pair.
  assumes mode held stable by the owner of the protection settings.
*/
`timescale 1ns/1ns
module flash_pair_prot (
  // mode
  input  wire [1:0] mode_i,
  // access kind
  input  wire       modify_i,
  input  wire       data_rd_i,
  // verdict
  output wire       deny_modify_o,
  output wire       deny_read_o
);
`include "flash_ctl_regs.vh"

  assign deny_modify_o = modify_i &&
    ((mode_i == `PROT_RDONLY) || (mode_i == `PROT_XONLY)); // R5
  assign deny_read_o = data_rd_i && (mode_i == `PROT_XONLY); // R7

endmodule

// ---- testbench.sv ----
/* bench for flash_ctl. assumes cpu_side drives requests at falling edges. */
`timescale 1ns/1ns
module testbench;
  reg         clock_i = 1'b0, rst_i = 1'b1, viol_clr_i = 1'b0;
  reg  [15:0] prot_i = 16'h0000;
  reg  [31:0] v;
  reg  [11:0] a;
  wire [4:0]  rq;
  wire [11:0] ad;
  wire [31:0] wd, fd, dd;
  wire        dny, mdn, bsy, dn, vio;
  integer     failures = 0, n_compared = 0, seed = 10;
  always #50 clock_i = ~clock_i;
  cpu_side u_cpu_side (.clock_i(clock_i), .req_o(rq), .addr_o(ad), .wd_o(wd));
  flash_ctl u_flash_ctl (.clock_i(clock_i), .rst_i(rst_i), .fetch_i(rq[0]), .fetch_addr_i(ad),
    .fetch_data_o(fd), .data_rd_i(rq[1]), .dbg_rd_i(rq[2]), .data_addr_i(ad), .data_data_o(dd),
    .data_deny_o(dny), .prog_i(rq[3]), .erase_i(rq[4]), .mod_addr_i(ad), .prog_data_i(wd),
    .mod_deny_o(mdn), .busy_o(bsy), .done_o(dn), .prot_i(prot_i), .viol_clr_i(viol_clr_i),
    .viol_o(vio));
  task chk(input [32:0] g, input [32:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task rd(input [4:0] r, input [31:0] e, input x);
    begin
      u_cpu_side.go(r, a, 32'h00000000);
      chk({dny, r[0] ? fd : dd}, {x, e});
      @(negedge clock_i);
    end
  endtask
  task er(input [11:0] b);
    begin
      u_cpu_side.go(5'h10, b, 32'h00000000);
      repeat (256) @(negedge clock_i);
      chk({dn, bsy}, 2'b10);
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2000) @(posedge clock_i);
    failures = failures + 1;
    wrap_up;
  end
  initial begin
    repeat (3) @(negedge clock_i);
    rst_i = 1'b0;
    er(12'h000);
    er(12'h100);
    a = 12'h100 | ($random(seed) & 12'h0FF);
    v = $random(seed);
    u_cpu_side.go(5'h08, a, v);
    @(negedge clock_i);
    er(12'h000);
    rd(5'h02, v, 1'b0);
    a = 12'h0FF;
    rd(5'h04, 32'hFFFFFFFF, 1'b0);
    $display("erase test done");
    prot_i = 16'h0001;
    u_cpu_side.go(5'h10, a, 32'h00000000);
    chk({mdn, bsy, vio}, 3'h5);
    @(negedge clock_i);
    u_cpu_side.go(5'h08, 12'h1FF, 32'h00000000);
    chk({mdn, vio}, 2'h3);
    @(negedge clock_i);
    u_cpu_side.go(5'h08, 12'h200, 32'h00000000);
    chk({mdn, dn}, 2'h1);
    @(negedge clock_i);
    rd(5'h02, 32'hFFFFFFFF, 1'b0);
    viol_clr_i = 1'b1;
    @(negedge clock_i);
    viol_clr_i = 1'b0;
    chk(vio, 1'b0);
    prot_i = 16'h0002;
    rd(5'h02, 32'h00000000, 1'b1);
    rd(5'h04, 32'h00000000, 1'b1);
    u_cpu_side.go(5'h08, a, 32'h00000000);
    chk({mdn, vio}, 2'h3);
    @(negedge clock_i);
    rd(5'h01, 32'hFFFFFFFF, 1'b0);
    $display("protection test done");
    wrap_up;
  end
endmodule
